/* verilog/mmdec_pkg.sv */
/*
 * Constants for the memory map address decoder: region bounds, the
 * high system-register addresses and the region enumeration.
 * Assumes a 16-bit processor address bus.
 */
package mmdec_pkg;

    localparam int ADDR_W = 16;

    // ------------------------------------------------------------
    // Region bounds
    // ------------------------------------------------------------
    localparam logic [15:0] IO_LO = 16'h0000;
    localparam logic [15:0] IO_HI = 16'h003f;
    localparam logic [15:0] RSV_LO = 16'h0040;
    localparam logic [15:0] RSV_HI = 16'h007f;
    localparam logic [15:0] RAM_LO = 16'h0080;
    localparam logic [15:0] RAM_HI = 16'h00ff;
    localparam logic [15:0] AUX_LO = 16'h2800;
    localparam logic [15:0] AUX_HI = 16'h2dff;
    localparam logic [15:0] FLASH_LG_LO = 16'hee00;
    localparam logic [15:0] FLASH_SM_LO = 16'hf800;
    localparam logic [15:0] FLASH_HI = 16'hfdff;
    localparam logic [15:0] MON_LO = 16'hfe10;
    localparam logic [15:0] MON_HI = 16'hffaf;
    localparam logic [15:0] HIFL_LO = 16'hffb0;
    localparam logic [15:0] TRIM_ADDR = 16'hffc0;
    localparam logic [15:0] TRIM_RSV_ADDR = 16'hffc1;
    localparam logic [15:0] VEC_LO = 16'hffd0;
    localparam logic [15:0] VEC_HI = 16'hffff;

    // ------------------------------------------------------------
    // High system-register block
    // ------------------------------------------------------------
    localparam logic [15:0] SYS_BASE = 16'hfe00;
    localparam logic [15:0] BREAK_STATUS_REG = 16'hfe00;
    localparam logic [15:0] RESET_CAUSE_REG = 16'hfe01;
    localparam logic [15:0] BREAK_AUXILIARY_REG = 16'hfe02;
    localparam logic [15:0] BREAK_FLAG_CONTROL_REG = 16'hfe03;
    localparam logic [15:0] INTERRUPT_STATUS_ONE = 16'hfe04;
    localparam logic [15:0] INTERRUPT_STATUS_TWO = 16'hfe05;
    localparam logic [15:0] INTERRUPT_STATUS_THREE = 16'hfe06;
    localparam logic [15:0] FLASH_TEST_CONTROL_REG = 16'hfe07;
    localparam logic [15:0] FLASH_CONTROL_REG = 16'hfe08;
    localparam logic [15:0] BREAK_ADDRESS_HIGH = 16'hfe09;
    localparam logic [15:0] BREAK_ADDRESS_LOW = 16'hfe0a;
    localparam logic [15:0] BREAK_STATUS_CONTROL_REG = 16'hfe0b;
    localparam logic [15:0] LOW_VOLTAGE_STATUS_REG = 16'hfe0c;
    localparam logic [15:0] FLASH_TEST_LO = 16'hfe0d;
    localparam logic [15:0] FLASH_TEST_HI = 16'hfe0f;
    localparam int SYS_SEL_W = 16;

    // ------------------------------------------------------------
    // Regions, one-hot select bit positions
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MMDEC_NONE,
        MMDEC_IO,
        MMDEC_RSV,
        MMDEC_RAM,
        MMDEC_AUX,
        MMDEC_FLASH,
        MMDEC_SYS,
        MMDEC_MON,
        MMDEC_TRIM,
        MMDEC_VEC
    } mmdec_region_e;

    localparam int SEL_W = 9;
    localparam int SEL_IO = 0;
    localparam int SEL_RAM = 1;
    localparam int SEL_AUX = 2;
    localparam int SEL_FLASH = 3;
    localparam int SEL_SYS = 4;
    localparam int SEL_MON = 5;
    localparam int SEL_TRIM = 6;
    localparam int SEL_VEC = 7;
    localparam int SEL_RSV = 8;

endpackage : mmdec_pkg

/* verilog/mmdec_decoder.sv */
/*
 * Memory map address decoder: registers a one-hot region select, a
 * per-register select for the high system block, the I/O page offset
 * and an illegal-address reset request for each bus cycle.
 * Assumes the core presents addr_i with valid_i and fetch_i in the
 * same cycle; all outputs appear one clock later.
 */
`timescale 1ns/1ps
// Function
// R1 - Decode the whole 64-Kbyte space from a 16-bit core address.
// R2 - Select RAM for 0080 to 00FF.
// R3 - Raise an illegal-address reset request on a fetch from 0040-007F.
// R4 - Software must stay off unimplemented addresses.
// R5 - Software must stay off reserved addresses.
// R6 - Select the auxiliary ROM for 2800 to 2DFF.
// R7 - Select user flash from EE00 (large) or a smaller base, to FDFF.
// R8 - Place the break and reset status registers at FE00 to FE03.
// R9 - Place the three interrupt status registers at FE04 to FE06.
// R10 - Reserve FE07 for flash test control; FE08 selects flash control.
// R11 - Select break address high, low, status/control at FE09 to FE0B.
// R12 - Select low-voltage status at FE0C; FE0D to FE0F are flash test.
// R13 - Select the monitor ROM for FE10 to FFAF.
// R14 - FFC0 is the oscillator trim byte; FFC1 is reserved flash.
// R15 - Select the user vectors for FFD0 to FFFF.
// R16 - Select the I/O page for 0000 to 003F, passing the low six bits.
// R17 - Unmapped addresses assert no select and never stall the bus.
module mmdec_decoder #(
    parameter bit LARGE_FLASH = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Core bus
    input wire logic [mmdec_pkg::ADDR_W-1:0] addr_i,
    input wire logic valid_i,
    input wire logic fetch_i,
    // Region selects
    output logic [mmdec_pkg::SEL_W-1:0] region_sel_o,
    output logic [mmdec_pkg::SYS_SEL_W-1:0] sys_reg_sel_o,
    output logic [5:0] io_reg_idx_o,
    output logic [mmdec_pkg::ADDR_W-1:0] region_offset_o,
    output logic unmapped_o,
    // Reset request
    output logic illegal_addr_rst_o
);
    import mmdec_pkg::*;

    // ------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------
    mmdec_region_e region;
    logic [15:0] flash_lo;
    logic [15:0] base;

    assign flash_lo = LARGE_FLASH ? FLASH_LG_LO : FLASH_SM_LO; // R7

    always_comb
    begin
        region = MMDEC_NONE; // R17
        base = 16'h0000;
        // R1 full 16-bit compare, no aliasing
        if (addr_i <= IO_HI)
        begin
            region = MMDEC_IO; // R16
            base = IO_LO;
        end
        else if (addr_i >= RSV_LO && addr_i <= RSV_HI)
        begin
            region = MMDEC_RSV; // R3
            base = RSV_LO;
        end
        else if (addr_i >= RAM_LO && addr_i <= RAM_HI)
        begin
            region = MMDEC_RAM; // R2
            base = RAM_LO;
        end
        else if (addr_i >= AUX_LO && addr_i <= AUX_HI)
        begin
            region = MMDEC_AUX; // R6
            base = AUX_LO;
        end
        else if (addr_i >= flash_lo && addr_i <= FLASH_HI)
        begin
            region = MMDEC_FLASH; // R7
            base = flash_lo;
        end
        else if (addr_i >= SYS_BASE && addr_i <= FLASH_TEST_HI)
        begin
            region = MMDEC_SYS; // R8 R9 R10 R11 R12
            base = SYS_BASE;
        end
        else if (addr_i >= MON_LO && addr_i <= MON_HI)
        begin
            region = MMDEC_MON; // R13
            base = MON_LO;
        end
        else if (addr_i >= HIFL_LO && addr_i < VEC_LO)
        begin
            // Trim byte and spare flash bytes share one flash select
            region = MMDEC_TRIM; // R14
            base = HIFL_LO;
        end
        else if (addr_i >= VEC_LO)
        begin
            region = MMDEC_VEC; // R15
            base = VEC_LO;
        end
    end

    // ------------------------------------------------------------
    // Next-state and registers
    // ------------------------------------------------------------
    logic [SEL_W-1:0] region_sel_d, region_sel_q;
    logic [SYS_SEL_W-1:0] sys_reg_sel_d, sys_reg_sel_q;
    logic [5:0] io_reg_idx_d, io_reg_idx_q;
    logic [15:0] region_offset_d, region_offset_q;
    logic unmapped_d, unmapped_q;
    logic illegal_d, illegal_q;

    always_comb
    begin
        region_sel_d = '0;
        sys_reg_sel_d = '0;
        io_reg_idx_d = 6'h00;
        region_offset_d = 16'h0000;
        unmapped_d = 1'b0;
        illegal_d = 1'b0;
        if (valid_i)
        begin
            region_offset_d = addr_i - base;
            case (region)
                MMDEC_IO:
                begin
                    region_sel_d[SEL_IO] = 1'b1;
                    io_reg_idx_d = addr_i[5:0]; // R16
                end
                MMDEC_RSV:
                begin
                    region_sel_d[SEL_RSV] = 1'b1;
                    illegal_d = fetch_i; // R3
                end
                MMDEC_RAM: region_sel_d[SEL_RAM] = 1'b1;
                MMDEC_AUX: region_sel_d[SEL_AUX] = 1'b1;
                MMDEC_FLASH: region_sel_d[SEL_FLASH] = 1'b1;
                MMDEC_SYS:
                begin
                    region_sel_d[SEL_SYS] = 1'b1;
                    // One-hot per register, FE00 at bit 0 up to FE0F
                    sys_reg_sel_d[addr_i[3:0]] = 1'b1; // R8 R9 R10 R11 R12
                end
                MMDEC_MON: region_sel_d[SEL_MON] = 1'b1;
                MMDEC_TRIM: region_sel_d[SEL_TRIM] = 1'b1; // R14
                MMDEC_VEC: region_sel_d[SEL_VEC] = 1'b1;
                MMDEC_NONE:
                begin
                    // No select; read data undefined, no wait states
                    unmapped_d = 1'b1; // R17
                    region_offset_d = 16'h0000;
                end
                default: unmapped_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            region_sel_q <= '0;
            sys_reg_sel_q <= '0;
            io_reg_idx_q <= 6'h00;
            region_offset_q <= 16'h0000;
            unmapped_q <= 1'b0;
            illegal_q <= 1'b0;
        end
        else
        begin
            region_sel_q <= region_sel_d;
            sys_reg_sel_q <= sys_reg_sel_d;
            io_reg_idx_q <= io_reg_idx_d;
            region_offset_q <= region_offset_d;
            unmapped_q <= unmapped_d;
            illegal_q <= illegal_d;
        end
    end

    assign region_sel_o = region_sel_q;
    assign sys_reg_sel_o = sys_reg_sel_q;
    assign io_reg_idx_o = io_reg_idx_q;
    assign region_offset_o = region_offset_q;
    assign unmapped_o = unmapped_q;
    assign illegal_addr_rst_o = illegal_q;

endmodule : mmdec_decoder

/* tb/mmdec_monitor.sv */
/* Port checker for the address decoder.
   Assumes it is bound to every mmdec_decoder instance. */
`timescale 1ns/1ps
module mmdec_monitor (
    // Clock, reset and core bus
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [mmdec_pkg::ADDR_W-1:0] addr_i,
    input wire logic valid_i,
    input wire logic fetch_i,
    // Decoder outputs
    input wire logic [mmdec_pkg::SEL_W-1:0] region_sel_o,
    input wire logic [mmdec_pkg::SYS_SEL_W-1:0] sys_reg_sel_o,
    input wire logic [5:0] io_reg_idx_o,
    input wire logic [mmdec_pkg::ADDR_W-1:0] region_offset_o,
    input wire logic unmapped_o,
    input wire logic illegal_addr_rst_o
);
    import mmdec_pkg::*;
    // ------------------------------------------------------------
    // Properties, one cycle of latency
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence rsv_fetch;
        valid_i && fetch_i && addr_i[15:6] == 10'h001;
    endsequence
    property sel_at(logic [15:0] lo, logic [15:0] hi, logic [8:0] code);
        valid_i && addr_i >= lo && addr_i <= hi |=> region_sel_o == code;
    endproperty
    a_rsv_fetch:
        assert property (rsv_fetch |=> illegal_addr_rst_o) else $error("no rst");
    a_data_no_rst:
        assert property (valid_i && !fetch_i |=> !illegal_addr_rst_o)
            else $error("data rst");
    a_ram_select:
        assert property (sel_at(16'h0080, 16'h00ff, 9'h002)) else $error("ram");
    a_aux_select:
        assert property (sel_at(16'h2800, 16'h2dff, 9'h004)) else $error("aux");
    a_flash_select:
        assert property (sel_at(16'hee00, 16'hfdff, 9'h008)) else $error("fl");
    a_mon_select:
        assert property (sel_at(16'hfe10, 16'hffaf, 9'h020)) else $error("mon");
    a_vec_select:
        assert property (sel_at(16'hffd0, 16'hffff, 9'h080)) else $error("vec");
    a_trim_select:
        assert property (sel_at(16'hffb0, 16'hffcf, 9'h040)) else $error("trm");
    a_sys_onehot:
        assert property (valid_i && addr_i[15:4] == 12'hfe0
            |=> sys_reg_sel_o == 16'h1 << $past(addr_i[3:0])) else $error("sys");
    a_io_index:
        assert property (valid_i && addr_i[15:6] == 10'h000
            |=> io_reg_idx_o == $past(addr_i[5:0])) else $error("io");
    a_idle_quiet:
        assert property (!valid_i |=> region_sel_o == 9'h000 && !unmapped_o)
            else $error("idle");
endmodule : mmdec_monitor
bind mmdec_decoder mmdec_monitor u_mon (.ref_clk_i, .rst_n_i, .addr_i,
    .valid_i, .fetch_i, .region_sel_o, .sys_reg_sel_o, .io_reg_idx_o,
    .region_offset_o, .unmapped_o, .illegal_addr_rst_o);

/* tb/mmdec_core_model.sv */
/* Processor core model: presents one bus cycle per clock.
   Assumes the caller paces it from a single process. */
`timescale 1ns/1ps
module mmdec_core_model (
    // Clock
    input wire logic ref_clk_i,
    // Core bus
    output logic [15:0] addr_o,
    output logic valid_o,
    output logic fetch_o
);
    initial addr_o = 16'h0000;
    initial valid_o = 1'b0;
    initial fetch_o = 1'b0;
    // Changes only just after an edge so the decoder sees a stable cycle
    task issue(input logic [15:0] a, input logic v, input logic f);
        @(posedge ref_clk_i);
        addr_o <= a;
        valid_o <= v;
        fetch_o <= f;
    endtask : issue
endmodule : mmdec_core_model

/* tb/mmdec_decoder_bench.sv */
/* Self-checking bench for the address decoder.
   Assumes the core model and the bound monitor are compiled first. */
`timescale 1ns/1ps
module mmdec_decoder_bench;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] addr, off, sys, t_a = 16'h0000;
    logic valid, fetch, unm, ill, t_v = 1'b0, t_f = 1'b0;
    logic [8:0] sel;
    logic [5:0] idx;
    logic [31:0] r;
    int mismatches = 0;
    int checks = 0;
    // Region bounds indexed by select bit position
    logic [15:0] lo [9] = '{16'h0000, 16'h0080, 16'h2800, 16'hee00,
        16'hfe00, 16'hfe10, 16'hffb0, 16'hffd0, 16'h0040};
    logic [15:0] hi [9] = '{16'h003f, 16'h00ff, 16'h2dff, 16'hfdff,
        16'hfe0f, 16'hffaf, 16'hffcf, 16'hffff, 16'h007f};
    logic [15:0] corner [] = '{16'h0000, 16'h003f, 16'h0040, 16'h007f,
        16'h0080, 16'h00ff, 16'h0100, 16'h27ff, 16'h2800, 16'h2dff,
        16'h2e00, 16'hedff, 16'hee00, 16'hfdff, 16'hfe10, 16'hffaf,
        16'hffb0, 16'hffc0, 16'hffc1, 16'hffcf, 16'hffd0, 16'hffff};
    mmdec_core_model core (.ref_clk_i(ref_clk_i), .addr_o(addr),
        .valid_o(valid), .fetch_o(fetch));
    mmdec_decoder #(.LARGE_FLASH(1'b1)) dut (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .addr_i(addr), .valid_i(valid), .fetch_i(fetch),
        .region_sel_o(sel), .sys_reg_sel_o(sys), .io_reg_idx_o(idx),
        .region_offset_o(off), .unmapped_o(unm), .illegal_addr_rst_o(ill));
    // ------------------------------------------------------------
    // Expectations and checking
    // ------------------------------------------------------------
    function automatic logic [48:0] exp_out(input logic [15:0] a,
        input logic v, input logic f);
        logic [8:0] s;
        logic [15:0] b;
        s = 9'h000;
        b = 16'h0000;
        for (int i = 0; i < 9; i++)
            if (v && a >= lo[i] && a <= hi[i])
            begin
                s[i] = 1'b1;
                b = lo[i];
            end
        return {s, s[4] ? 16'h1 << a[3:0] : 16'h0, s[0] ? a[5:0] : 6'h0,
            s != 0 ? a - b : 16'h0, v && s == 0, s[8] & f};
    endfunction : exp_out
    task check(input logic [48:0] seen, input logic [48:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        if (mismatches == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    always #12.5 ref_clk_i = ~ref_clk_i;
    // Cycle taken at each edge; a reset edge takes nothing
    always @(posedge ref_clk_i)
    begin
        t_a <= addr;
        t_v <= valid & rst_n_i;
        t_f <= fetch;
    end
    always @(negedge ref_clk_i)
        check({sel, sys, idx, off, unm, ill}, exp_out(t_a, t_v, t_f));
    initial
    begin
        #125000;
        mismatches++;
        finish_test();
    end
    initial
    begin
        void'($urandom(54));
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        foreach (corner[i])
            for (int f = 0; f < 2; f++)
                core.issue(corner[i], 1'b1, f[0]);
        for (int i = 0; i < 16; i++)
            core.issue(16'hfe00 + i[15:0], 1'b1, i[0]);
        // Random traffic with about one cycle in four forced into 0040-007F, and a reset
        for (int n = 0; n < 3000; n++)
        begin
            r = $urandom;
            if (r[21:20] == 2'b00)
                r[15:6] = 10'h001;
            core.issue(r[15:0], r[17:16] != 2'b00, r[18]);
            rst_n_i <= !(n inside {[1500:1502]});
        end
        core.issue(16'h0000, 1'b0, 1'b0);
        core.issue(16'h0000, 1'b0, 1'b0);
        finish_test();
    end
endmodule : mmdec_decoder_bench
